// ### design/uer_first_err.sv
// priority encoder choosing the lowest new error position
`timescale 1ns/1ps
module uer_first_err (
  // events
  input wire logic [31:0] events,
  // result
  output logic found,
  output logic [uer_pkg::FEP_W-1:0] position
);
  function automatic logic [uer_pkg::FEP_W-1:0] lowest(input logic [31:0] v);
    logic [uer_pkg::FEP_W-1:0] p;
    p = '0;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        p = uer_pkg::FEP_W'(i);
      end
    end
    return p;
  endfunction

  assign found = |events;
  assign position = lowest(events);
endmodule // uer_first_err

// ### design/uer_regs.sv
// uncorrectable error status, mask, severity, pointer and header log
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module uer_regs (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // port role
  input wire logic upstream_port,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // error events, one-cycle pulses
  input wire logic ev_training,
  input wire logic ev_dl_protocol,
  input wire logic ev_poisoned_rx,
  input wire logic ev_poisoned_tx,
  input wire logic ev_fc_protocol,
  input wire logic ev_cpl_timeout,
  input wire logic ev_completer_abort,
  input wire logic ev_unexpected_cpl,
  input wire logic ev_rx_overflow,
  input wire logic ev_malformed,
  input wire logic ev_ecrc,
  input wire logic ev_unsupported,
  input wire logic ev_acs,
  input wire logic ev_mc_blocked,
  // header of the offending packet, valid with the event
  input wire logic [127:0] err_header,
  // error messages toward the root complex
  output logic msg_fatal,
  output logic msg_nonfatal
);
  localparam int FEPW = uer_pkg::FEP_W;
  logic [31:0] status_r;
  logic [31:0] status_nxt;
  logic [31:0] mask_r;
  logic [31:0] sev_r;
  logic [FEPW-1:0] fep_r;
  logic log_valid_r;
  logic [31:0] hlog_r [0:3];
  logic msg_fatal_r;
  logic msg_nonfatal_r;
  logic [31:0] rdata_r;

  wire logic [31:0] ev_vec;
  wire logic [31:0] w1c;
  wire logic [31:0] unmasked;
  wire logic fe_found;
  wire logic [FEPW-1:0] fe_pos;
  wire logic take_log;
  wire logic any_fatal;
  wire logic any_nonfatal;
  wire logic [11:0] next_ptr;
  wire logic [31:0] cap_hdr;
  wire logic [31:0] err_ctrl;
  wire logic wr_status;
  wire logic wr_mask;
  wire logic wr_sev;
  wire logic hlog_hit;
  wire logic [1:0] hlog_idx;
  wire logic [31:0] rd_mux;

  assign ev_vec[uer_pkg::BIT_TRAIN] = ev_training;
  assign ev_vec[3:1] = 3'h0;
  assign ev_vec[uer_pkg::BIT_DLP] = ev_dl_protocol;
  assign ev_vec[11:5] = 7'h00;
  assign ev_vec[uer_pkg::BIT_POISON] = ev_poisoned_rx | ev_poisoned_tx;
  assign ev_vec[uer_pkg::BIT_FC] = ev_fc_protocol;
  assign ev_vec[uer_pkg::BIT_CPL_TO] = ev_cpl_timeout;
  assign ev_vec[uer_pkg::BIT_CA] = ev_completer_abort;
  assign ev_vec[uer_pkg::BIT_UC] = ev_unexpected_cpl;
  assign ev_vec[uer_pkg::BIT_RX_OVF] = ev_rx_overflow;
  assign ev_vec[uer_pkg::BIT_MALF] = ev_malformed;
  assign ev_vec[uer_pkg::BIT_ECRC] = ev_ecrc;
  assign ev_vec[uer_pkg::BIT_UR] = ev_unsupported;
  assign ev_vec[uer_pkg::BIT_ACS] = ev_acs;
  assign ev_vec[22] = 1'b0;
  assign ev_vec[uer_pkg::BIT_MC_BLK] = ev_mc_blocked;
  assign ev_vec[31:24] = 8'h00;

  // address decode
  assign wr_status = reg_wr && (reg_addr == uer_pkg::OFS_STATUS);
  assign wr_mask = reg_wr && (reg_addr == uer_pkg::OFS_MASK);
  assign wr_sev = reg_wr && (reg_addr == uer_pkg::OFS_SEVERITY);
  assign hlog_hit = (reg_addr >= uer_pkg::OFS_HDR_LOG0)
    && (reg_addr <= uer_pkg::OFS_HDR_LOG3) && (reg_addr[1:0] == 2'h0);
  assign hlog_idx = reg_addr[3:2];

  // write-one clear, a new event wins over the clear
  assign w1c = wr_status ? (reg_wdata & uer_pkg::EVT_IMPL) : 32'h0000_0000;
  assign status_nxt = (status_r & ~w1c) | ev_vec;

  assign unmasked = ev_vec & ~mask_r;

  uer_first_err u_first (
    .events(unmasked),
    .found(fe_found),
    .position(fe_pos)
  );

  // header log holds one error until its status bit is cleared
  assign take_log = fe_found && !log_valid_r;

  assign any_fatal = |(unmasked & sev_r);
  assign any_nonfatal = |(unmasked & ~sev_r);

  assign next_ptr = upstream_port ? uer_pkg::NEXT_PTR_UP
    : uer_pkg::NEXT_PTR_DOWN;
  assign cap_hdr = {next_ptr, uer_pkg::CAP_VERSION, uer_pkg::CAP_ID};
  assign err_ctrl = {27'h0000000, fep_r};

  assign rd_mux =
    (reg_addr == uer_pkg::OFS_CAP_HDR) ? cap_hdr :
    (reg_addr == uer_pkg::OFS_STATUS) ? (status_r & uer_pkg::EVT_IMPL) :
    (reg_addr == uer_pkg::OFS_MASK) ? (mask_r & uer_pkg::EVT_IMPL) :
    (reg_addr == uer_pkg::OFS_SEVERITY) ? (sev_r & uer_pkg::EVT_IMPL) :
    (reg_addr == uer_pkg::OFS_ERR_CTRL) ? err_ctrl :
    hlog_hit ? hlog_r[hlog_idx] : 32'h0000_0000;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      status_r <= 32'h0000_0000;
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mask_r <= uer_pkg::MASK_RESET;
    end else if (wr_mask) begin
      mask_r <= reg_wdata & uer_pkg::EVT_IMPL;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sev_r <= uer_pkg::SEV_RESET;
    end else if (wr_sev) begin
      sev_r <= reg_wdata & uer_pkg::EVT_IMPL;
    end
  end

  // pointer frozen while a log is held
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fep_r <= '0;
      log_valid_r <= 1'b0;
    end else if (take_log) begin
      fep_r <= fe_pos;
      log_valid_r <= 1'b1;
    end else if (log_valid_r && !status_nxt[fep_r]) begin
      log_valid_r <= 1'b0;
    end
  end

  // capture header words, byte order kept as given
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        hlog_r[i] <= 32'h0000_0000;
      end
    end else if (take_log) begin
      for (int i = 0; i < 4; i++) begin
        hlog_r[i] <= err_header[32*i +: 32];
      end
    end
  end

  // one message pulse per severity per unmasked event cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      msg_fatal_r <= 1'b0;
      msg_nonfatal_r <= 1'b0;
    end else begin
      msg_fatal_r <= any_fatal;
      msg_nonfatal_r <= any_nonfatal;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (reg_rd) begin
      rdata_r <= rd_mux;
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_r;
  assign msg_fatal = msg_fatal_r;
  assign msg_nonfatal = msg_nonfatal_r;

  property p_event_sets;
    @(posedge clock) disable iff (sys_rst)
      ev_training |=> status_r[0];
  endproperty
  a_event_sets: assert property (p_event_sets)
    else $error("training event did not set status");

  property p_hold;
    @(posedge clock) disable iff (sys_rst)
      (status_r[4] && !(wr_status && reg_wdata[4])) |=> status_r[4];
  endproperty
  a_hold: assert property (p_hold)
    else $error("status bit 4 dropped without clear");

  property p_poison;
    @(posedge clock) disable iff (sys_rst)
      (ev_poisoned_rx || ev_poisoned_tx) |=> status_r[12];
  endproperty
  a_poison: assert property (p_poison)
    else $error("poisoned packet not recorded");

  property p_masked_quiet;
    @(posedge clock) disable iff (sys_rst)
      (ev_vec == 32'h0000_2000 && mask_r[13]) |=> !msg_fatal && !msg_nonfatal;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet)
    else $error("masked error produced a message");

  property p_fatal_msg;
    @(posedge clock) disable iff (sys_rst)
      (ev_training && !mask_r[0] && sev_r[0]) |=> msg_fatal;
  endproperty
  a_fatal_msg: assert property (p_fatal_msg)
    else $error("fatal error sent no fatal message");

  property p_nonfatal_msg;
    @(posedge clock) disable iff (sys_rst)
      (ev_ecrc && !mask_r[19] && !sev_r[19]) |=> msg_nonfatal;
  endproperty
  a_nonfatal_msg: assert property (p_nonfatal_msg)
    else $error("non-fatal error sent no non-fatal message");

  property p_sev_reset;
    @(posedge clock) $fell(sys_rst)
      |-> sev_r == uer_pkg::SEV_RESET && mask_r == uer_pkg::MASK_RESET;
  endproperty
  a_sev_reset: assert property (p_sev_reset)
    else $error("severity or mask reset value wrong");

  property p_first_ptr;
    @(posedge clock) disable iff (sys_rst)
      take_log |=> fep_r == $past(fe_pos) && log_valid_r;
  endproperty
  a_first_ptr: assert property (p_first_ptr)
    else $error("first error pointer not captured");

  property p_hdr_log;
    @(posedge clock) disable iff (sys_rst)
      take_log |=> hlog_r[0] == $past(err_header[31:0]);
  endproperty
  a_hdr_log: assert property (p_hdr_log)
    else $error("header log not captured");

  property p_reserved;
    @(posedge clock) disable iff (sys_rst)
      (reg_rd && reg_addr == 12'hFB8) |=> reg_rdata[31:24] == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved status bits not zero");

  property p_cap_hdr;
    @(posedge clock) disable iff (sys_rst)
      (reg_rd && reg_addr == 12'hFB4 && upstream_port)
        |=> reg_rdata == 32'h1381_0001;
  endproperty
  a_cap_hdr: assert property (p_cap_hdr)
    else $error("capability header wrong on upstream port");
endmodule // uer_regs

// ### shared/uer_pkg.sv
// constants for the uncorrectable error reporting register bank
package uer_pkg;
  localparam logic [11:0] OFS_CAP_HDR = 12'hFB4;
  localparam logic [11:0] OFS_STATUS = 12'hFB8;
  localparam logic [11:0] OFS_MASK = 12'hFBC;
  localparam logic [11:0] OFS_SEVERITY = 12'hFC0;
  localparam logic [11:0] OFS_ERR_CTRL = 12'hFCC;
  localparam logic [11:0] OFS_HDR_LOG0 = 12'hFD0;
  localparam logic [11:0] OFS_HDR_LOG3 = 12'hFDC;
  localparam logic [15:0] CAP_ID = 16'h0001;
  localparam logic [3:0] CAP_VERSION = 4'h1;
  localparam logic [11:0] NEXT_PTR_UP = 12'h138;
  localparam logic [11:0] NEXT_PTR_DOWN = 12'h148;
  localparam int CAP_VER_LSB = 16;
  localparam int NEXT_PTR_LSB = 20;
  // implemented event bits: 0,4,12..21,23
  localparam logic [31:0] EVT_IMPL = 32'h00BF_F011;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  // fatal at reset: 0,4,13,17,18
  localparam logic [31:0] SEV_RESET = 32'h0006_2011;
  localparam int BIT_TRAIN = 0;
  localparam int BIT_DLP = 4;
  localparam int BIT_POISON = 12;
  localparam int BIT_FC = 13;
  localparam int BIT_CPL_TO = 14;
  localparam int BIT_CA = 15;
  localparam int BIT_UC = 16;
  localparam int BIT_RX_OVF = 17;
  localparam int BIT_MALF = 18;
  localparam int BIT_ECRC = 19;
  localparam int BIT_UR = 20;
  localparam int BIT_ACS = 21;
  localparam int BIT_MC_BLK = 23;
  localparam int FEP_W = 5;
endpackage

// ### tb/testbench.sv
// self-checking bench for the uncorrectable error register bank
`timescale 1ns/1ps
module testbench;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic upstream_port = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [13:0] ev;
  logic [127:0] hdr;
  logic msg_fatal;
  logic msg_nonfatal;
  logic rd_seen = 1'b0;
  logic ev_seen = 1'b0;
  logic [31:0] rd_q[$];
  logic [1:0] msg_q[$];
  int bad_count = 0;
  int check_count = 0;
  int bit_of[14] = '{0, 4, 12, 12, 13, 14, 15, 16, 17, 18, 19, 20, 21, 23};
  logic [31:0] sev;
  logic [31:0] msk;
  logic [127:0] h;
  int b;

  initial begin
    forever #20 clock = ~clock;
  end

  uer_link_model peer (.clock(clock), .ev(ev), .hdr(hdr));

  uer_regs dut (
    .clock(clock), .sys_rst(sys_rst), .upstream_port(upstream_port),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ev_training(ev[0]), .ev_dl_protocol(ev[1]), .ev_poisoned_rx(ev[2]),
    .ev_poisoned_tx(ev[3]), .ev_fc_protocol(ev[4]),
    .ev_cpl_timeout(ev[5]), .ev_completer_abort(ev[6]),
    .ev_unexpected_cpl(ev[7]), .ev_rx_overflow(ev[8]),
    .ev_malformed(ev[9]), .ev_ecrc(ev[10]), .ev_unsupported(ev[11]),
    .ev_acs(ev[12]), .ev_mc_blocked(ev[13]), .err_header(hdr),
    .msg_fatal(msg_fatal), .msg_nonfatal(msg_nonfatal)
  );

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
  endtask

  // read data and messages are sampled before this edge's updates land
  always @(posedge clock) begin
    if (!sys_rst) begin
      if (rd_seen)
        check("rdata", reg_rdata, rd_q.pop_front());
      else
        check("idle rdata", reg_rdata, 32'h0000_0000);
      if (ev_seen)
        check("msg", {30'h0, msg_fatal, msg_nonfatal},
              {30'h0, msg_q.pop_front()});
      else
        check("idle msg", {30'h0, msg_fatal, msg_nonfatal}, 32'h0);
    end
    rd_seen <= reg_rd;
    ev_seen <= |ev;
  end

  initial begin
    #(40 * 20000);
    bad_count++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'hdb56));
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    rd(uer_pkg::OFS_CAP_HDR, 32'h1381_0001);
    wr(uer_pkg::OFS_CAP_HDR, 32'hFFFF_FFFF);
    rd(uer_pkg::OFS_CAP_HDR, 32'h1381_0001);
    upstream_port <= 1'b0;
    rd(uer_pkg::OFS_CAP_HDR, 32'h1481_0001);
    rd(uer_pkg::OFS_STATUS, 32'h0000_0000);
    rd(uer_pkg::OFS_MASK, 32'h0000_0000);
    rd(uer_pkg::OFS_SEVERITY, 32'h0006_2011);
    rd(12'hFB0, 32'h0000_0000);
    sev = 32'h0006_2011;
    msk = 32'h0000_0000;
    // pass 0 reset severity, pass 1 random severity, pass 2 all masked
    for (int p = 0; p < 3; p++) begin
      if (p == 1) begin
        sev = $urandom();
        wr(uer_pkg::OFS_SEVERITY, sev);
        sev = sev & 32'h00BF_F011;
        rd(uer_pkg::OFS_SEVERITY, sev);
      end
      if (p == 2) begin
        wr(uer_pkg::OFS_MASK, 32'hFFFF_FFFF);
        msk = 32'h00BF_F011;
        rd(uer_pkg::OFS_MASK, msk);
      end
      for (int i = 0; i < 14; i++) begin
        b = bit_of[i];
        h = {$urandom(), $urandom(), $urandom(), $urandom()};
        msg_q.push_back({~msk[b] & sev[b], ~msk[b] & ~sev[b]});
        peer.fire(i, h);
        rd(uer_pkg::OFS_STATUS, 32'h1 << b);
        if (!msk[b]) begin
          rd(uer_pkg::OFS_ERR_CTRL, b);
          for (int w = 0; w < 4; w++)
            rd(uer_pkg::OFS_HDR_LOG0 + 12'(4 * w), h[32 * w +: 32]);
        end
        wr(uer_pkg::OFS_STATUS, 32'h1 << b);
        rd(uer_pkg::OFS_STATUS, 32'h0000_0000);
      end
    end
    // two errors at once beside a clear of both: set wins, lowest logs
    wr(uer_pkg::OFS_MASK, 32'h0000_0000);
    h = {$urandom(), $urandom(), $urandom(), $urandom()};
    msg_q.push_back({sev[13] | sev[23], ~sev[13] | ~sev[23]});
    fork
      wr(uer_pkg::OFS_STATUS, 32'h0080_2000);
      peer.fire_set(14'h2010, h);
    join
    rd(uer_pkg::OFS_STATUS, 32'h0080_2000);
    rd(uer_pkg::OFS_ERR_CTRL, 32'h0000_000D);
    rd(uer_pkg::OFS_HDR_LOG0, h[31:0]);
    repeat (3) @(posedge clock);
    tally_and_finish();
  end
endmodule // testbench

// ### tb/uer_link_model.sv
// error event source standing in for the port's link and transaction layers
`timescale 1ns/1ps
module uer_link_model (
  // clock
  input wire logic clock,
  // error pulses and the header that goes with them
  output logic [13:0] ev,
  output logic [127:0] hdr
);
  initial begin
    ev = 14'h0000;
    hdr = 128'hA5A5_5A5A_0F0F_F0F0_3C3C_C3C3_9696_6969;
  end
  task automatic fire(input int idx, input logic [127:0] h);
    fire_set(14'h0001 << idx, h);
  endtask
  // several errors in one cycle share one header
  task automatic fire_set(input logic [13:0] v, input logic [127:0] h);
    @(posedge clock);
    ev <= v;
    hdr <= h;
    @(posedge clock);
    ev <= 14'h0000;
    // header is only valid beside its pulse, so never leave it looking fresh
    hdr <= ~h;
  endtask
endmodule // uer_link_model
